//--- rtl/svts_pkg.sv
// Types shared by the supervisor timing sequencer
// Assumes the constants header is on the include path
package svts_pkg;

    typedef enum logic [2:0] {
        SVTS_PWR_LOAD = 3'b001,
        SVTS_PWR_TEST = 3'b010,
        SVTS_PWR_READY = 3'b100
    } svts_pwr_state_t;

    typedef struct packed {
        logic [1:0] esm_deb;
        logic [2:0] wdo_dly;
        logic [2:0] rst_dly;
    } svts_ctrl_t;

    typedef struct packed {
        logic ready;
        logic wdog;
        logic error_signal_input;
        logic [2:0] fast;
    } svts_events_t;

endpackage

//--- rtl/svts_regs.svh
// Register offsets, field positions, reset values and timing constants
// Assumes inclusion by the timing sequencer top module and the bench only
`ifndef SVTS_REGS_SVH
`define SVTS_REGS_SVH

// ****************************************
// Clock and timebase
// ****************************************
`define SVTS_CLK_PERIOD_NS 100
`define SVTS_TICK_US 1

// ****************************************
// Register offsets
// ****************************************
`define SVTS_ADDR_CTRL 8'h00
`define SVTS_ADDR_FILT 8'h04
`define SVTS_ADDR_STATUS 8'h08
`define SVTS_ADDR_MASK 8'h0C
`define SVTS_ADDR_STATE 8'h10

// ****************************************
// Field positions
// ****************************************
`define SVTS_CTRL_RDLY_LSB 0
`define SVTS_CTRL_WDLY_LSB 3
`define SVTS_CTRL_ESM_LSB 6
`define SVTS_FILT_W 10
`define SVTS_ST_FAST_LSB 0
`define SVTS_ST_ESM_BIT 3
`define SVTS_ST_WDOG_BIT 4
`define SVTS_ST_READY_BIT 5

// ****************************************
// Reset values
// ****************************************
`define SVTS_CTRL_RESET 8'h00
`define SVTS_FILT_RESET 10'h3FF
`define SVTS_MASK_RESET 6'h1F

// ****************************************
// Timing, in microseconds
// ****************************************
`define SVTS_LOAD_US 1000
`define SVTS_BIST_US 10000
`define SVTS_RDLY0_US 200
`define SVTS_RDLY1_US 1000
`define SVTS_RDLY2_US 10000
`define SVTS_RDLY3_US 16000
`define SVTS_RDLY4_US 20000
`define SVTS_RDLY5_US 70000
`define SVTS_RDLY6_US 100000
`define SVTS_RDLY7_US 200000
`define SVTS_WDLY0_US 1000
`define SVTS_WDLY1_US 2000
`define SVTS_WDLY2_US 5000
`define SVTS_WDLY3_US 10000
`define SVTS_WDLY4_US 20000
`define SVTS_WDLY5_US 50000
`define SVTS_WDLY6_US 100000
`define SVTS_WDLY7_US 200000
`define SVTS_ESM0_US 10
`define SVTS_ESM1_US 25
`define SVTS_ESM2_US 50
`define SVTS_ESM3_US 100

`endif

//--- rtl/svts_top.sv
// Supervisor timing sequencer: power-up sequence, fault filtering and
// the reset, watchdog and interrupt output timing.
// Assumes one 10 MHz clock, pins synchronised here, and a watchdog
// violation pulse from logic on the same clock.
`timescale 1ns/100ps
`include "svts_regs.svh"

// Overview of operation
// R1 - With self test chosen, ready within 12 ms of power-on, load included
// R2 - Without self test, ready within 2 ms of power-on, load included
// R3 - Serial register access opens the same edge self test completes
// R4 - Reset output goes low within 25 us of a detected fault
// R5 - Watchdog output goes low within 25 us of a watchdog fault
// R6 - Interrupt for non fast faults asserts within 25 us
// R7 - Fast faults reach detection within the filter time plus little delay
// R8 - Three-bit field picks reset delay 200us(chosen),1,10,16,20,70,100,200 ms
// R9 - Three-bit field picks watchdog delay 1,2,5,10,20,50,100,200 ms
// R10 - Two-bit field picks error input debounce 10,25,50,100 us
// R11 - Per channel fast fault filter spans 0.1 us to 102.4 us
// R12 - After reset filters are 102.4 us and fault interrupts enabled
// R13 - Reset output releases only after full delay with no fault
module svts_top import svts_pkg::*; #(
    parameter int TICK_US = `SVTS_TICK_US
) (
    input wire logic clk_in, // 10 MHz clock
    input wire logic rst_n_in, // Async reset, active low
    input wire logic self_test_on_power_up_in, // Strap: run self test
    input wire logic [2:0] fast_fault_in, // Raw OV/UV comparator per channel
    input wire logic error_signal_input_in, // Error signal pin, high is error
    input wire logic watchdog_violation_in, // One-cycle watchdog fault pulse
    input wire logic [7:0] addr_in, // Register byte address
    input wire logic [31:0] wr_data_in, // Write data
    input wire logic wr_en_in, // Write strobe
    input wire logic rd_en_in, // Read strobe
    output logic [31:0] rd_data_out, // Read data, cycle after strobe
    output logic reset_output_n_out, // Reset pin level
    output logic reset_output_oe_out, // Reset pin driven low
    output logic watchdog_fault_output_n_out, // Watchdog pin level
    output logic watchdog_fault_output_oe_out, // Watchdog pin driven low
    output logic interrupt_output_n_out, // Interrupt pin level
    output logic interrupt_output_oe_out, // Interrupt pin driven low
    output logic ready_out, // Power-up sequence complete
    output logic serial_active_out // Register access open
);

    localparam int TICK_CYCLES = TICK_US * 1000 / `SVTS_CLK_PERIOD_NS;

    // Time to timebase ticks, rounded down, at least one
    function automatic logic [17:0] to_ticks(input int us);
        int t;
        t = us / TICK_US;
        if (t < 1) begin
            t = 1;
        end
        return 18'(t);
    endfunction

    // Debounce time to clock cycles
    function automatic logic [9:0] to_cycles(input int us);
        return 10'(us * 1000 / `SVTS_CLK_PERIOD_NS - 1);
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    wire logic [2:0] fast_s = sync_b[2:0];
    wire logic esm_s = sync_b[3];
    wire logic strap_s = sync_b[4];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end else begin
            sync_a <= {self_test_on_power_up_in, error_signal_input_in, fast_fault_in};
            sync_b <= sync_a;
        end
    end

    // ****************************************
    // Timebase
    // ****************************************
    logic [15:0] tick_cnt;
    wire logic tick = (tick_cnt == 16'(TICK_CYCLES - 1));

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    svts_ctrl_t ctrl;
    logic [29:0] filt;
    logic [5:0] status;
    logic [5:0] mask;
    svts_events_t events;
    logic ready;

    wire logic acc_wr = wr_en_in && ready; // R3
    wire logic acc_rd = rd_en_in && ready; // R3
    wire logic wr_ctrl = acc_wr && (addr_in == `SVTS_ADDR_CTRL);
    wire logic wr_filt = acc_wr && (addr_in == `SVTS_ADDR_FILT);
    wire logic wr_stat = acc_wr && (addr_in == `SVTS_ADDR_STATUS);
    wire logic wr_mask = acc_wr && (addr_in == `SVTS_ADDR_MASK);
    wire logic [5:0] clr_bits = wr_stat ? wr_data_in[5:0] : 6'h00;
    wire logic [5:0] next_status = (status & ~clr_bits) | events;
    wire svts_ctrl_t next_ctrl = '{
        esm_deb: wr_data_in[`SVTS_CTRL_ESM_LSB +: 2],
        wdo_dly: wr_data_in[`SVTS_CTRL_WDLY_LSB +: 3],
        rst_dly: wr_data_in[`SVTS_CTRL_RDLY_LSB +: 3]};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= `SVTS_CTRL_RESET;
            filt <= {3{`SVTS_FILT_RESET}}; // R12
            mask <= `SVTS_MASK_RESET; // R12
            status <= 6'h00;
        end else begin
            ctrl <= wr_ctrl ? next_ctrl : ctrl;
            filt <= wr_filt ? wr_data_in[29:0] : filt; // R11
            mask <= wr_mask ? wr_data_in[5:0] : mask;
            status <= next_status;
        end
    end

    // ****************************************
    // Power-up sequence
    // ****************************************
    svts_pwr_state_t pwr_state;
    logic [17:0] pwr_cnt;
    logic test_sel;
    wire logic load_done = tick && (pwr_cnt == to_ticks(`SVTS_LOAD_US) - 18'h00001);
    wire logic bist_done = tick && (pwr_cnt == to_ticks(`SVTS_BIST_US) - 18'h00001);
    logic go_ready;

    always_comb begin
        go_ready = 1'b0;
        unique case (pwr_state)
            SVTS_PWR_LOAD: go_ready = load_done && !strap_s; // R2
            SVTS_PWR_TEST: go_ready = bist_done; // R1
            SVTS_PWR_READY: go_ready = 1'b0;
            default: go_ready = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwr_state <= SVTS_PWR_LOAD;
            pwr_cnt <= 18'h00000;
            test_sel <= 1'b0;
            ready <= 1'b0;
        end else begin
            ready <= ready | go_ready; // R3
            unique case (pwr_state)
                SVTS_PWR_LOAD: begin
                    if (load_done) begin
                        test_sel <= strap_s;
                        pwr_state <= strap_s ? SVTS_PWR_TEST : SVTS_PWR_READY;
                        pwr_cnt <= 18'h00000;
                    end else if (tick) begin
                        pwr_cnt <= pwr_cnt + 18'h00001;
                    end
                end
                SVTS_PWR_TEST: begin
                    if (bist_done) begin
                        pwr_state <= SVTS_PWR_READY; // R1
                    end else if (tick) begin
                        pwr_cnt <= pwr_cnt + 18'h00001;
                    end
                end
                SVTS_PWR_READY: pwr_state <= SVTS_PWR_READY;
                default: pwr_state <= SVTS_PWR_LOAD;
            endcase
        end
    end

    // ****************************************
    // Fast fault deglitch, one per channel
    // ****************************************
    logic [2:0] fast_det;

    for (genvar ch = 0; ch < 3; ch++) begin : g_fast
        logic [9:0] cnt;
        wire logic [9:0] setting = filt[ch * `SVTS_FILT_W +: `SVTS_FILT_W];
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                cnt <= 10'h000;
                fast_det[ch] <= 1'b0;
            end else if (!fast_s[ch]) begin
                cnt <= 10'h000;
                fast_det[ch] <= 1'b0;
            end else if (cnt >= setting) begin
                fast_det[ch] <= 1'b1; // R7 R11
            end else begin
                cnt <= cnt + 10'h001;
            end
        end
    end

    // ****************************************
    // Error signal input debounce
    // ****************************************
    logic [9:0] esm_cnt;
    logic esm_det;
    logic [9:0] esm_limit;

    always_comb begin
        esm_limit = to_cycles(`SVTS_ESM0_US);
        unique case (ctrl.esm_deb) // R10
            2'h0: esm_limit = to_cycles(`SVTS_ESM0_US);
            2'h1: esm_limit = to_cycles(`SVTS_ESM1_US);
            2'h2: esm_limit = to_cycles(`SVTS_ESM2_US);
            2'h3: esm_limit = to_cycles(`SVTS_ESM3_US);
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            esm_cnt <= 10'h000;
            esm_det <= 1'b0;
        end else if (!esm_s) begin
            esm_cnt <= 10'h000;
            esm_det <= 1'b0;
        end else if (esm_cnt >= esm_limit) begin
            esm_det <= 1'b1; // R10
        end else begin
            esm_cnt <= esm_cnt + 10'h001;
        end
    end

    // ****************************************
    // Delay selection
    // ****************************************
    logic [17:0] rst_limit;
    logic [17:0] wdo_limit;

    always_comb begin
        rst_limit = to_ticks(`SVTS_RDLY0_US);
        unique case (ctrl.rst_dly) // R8
            3'h0: rst_limit = to_ticks(`SVTS_RDLY0_US);
            3'h1: rst_limit = to_ticks(`SVTS_RDLY1_US);
            3'h2: rst_limit = to_ticks(`SVTS_RDLY2_US);
            3'h3: rst_limit = to_ticks(`SVTS_RDLY3_US);
            3'h4: rst_limit = to_ticks(`SVTS_RDLY4_US);
            3'h5: rst_limit = to_ticks(`SVTS_RDLY5_US);
            3'h6: rst_limit = to_ticks(`SVTS_RDLY6_US);
            3'h7: rst_limit = to_ticks(`SVTS_RDLY7_US);
        endcase
        wdo_limit = to_ticks(`SVTS_WDLY0_US);
        unique case (ctrl.wdo_dly) // R9
            3'h0: wdo_limit = to_ticks(`SVTS_WDLY0_US);
            3'h1: wdo_limit = to_ticks(`SVTS_WDLY1_US);
            3'h2: wdo_limit = to_ticks(`SVTS_WDLY2_US);
            3'h3: wdo_limit = to_ticks(`SVTS_WDLY3_US);
            3'h4: wdo_limit = to_ticks(`SVTS_WDLY4_US);
            3'h5: wdo_limit = to_ticks(`SVTS_WDLY5_US);
            3'h6: wdo_limit = to_ticks(`SVTS_WDLY6_US);
            3'h7: wdo_limit = to_ticks(`SVTS_WDLY7_US);
        endcase
    end

    // ****************************************
    // Reset output timing
    // ****************************************
    wire logic fault_any = (|fast_det) || esm_det || watchdog_violation_in;
    logic [17:0] rst_cnt;
    wire logic rst_hold = !ready || fault_any;
    wire logic rst_elapsed = (rst_cnt >= rst_limit);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_cnt <= 18'h00000;
            reset_output_n_out <= 1'b0;
            reset_output_oe_out <= 1'b1;
        end else if (rst_hold) begin
            rst_cnt <= 18'h00000; // R13
            reset_output_n_out <= 1'b0; // R4
            reset_output_oe_out <= 1'b1;
        end else if (rst_elapsed) begin
            reset_output_n_out <= 1'b1; // R13
            reset_output_oe_out <= 1'b0;
        end else if (tick) begin
            rst_cnt <= rst_cnt + 18'h00001;
        end
    end

    // ****************************************
    // Watchdog output timing
    // ****************************************
    logic [17:0] wdo_cnt;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wdo_cnt <= 18'h00000;
            watchdog_fault_output_n_out <= 1'b1;
            watchdog_fault_output_oe_out <= 1'b0;
        end else if (watchdog_violation_in) begin
            wdo_cnt <= 18'h00000;
            watchdog_fault_output_n_out <= 1'b0; // R5
            watchdog_fault_output_oe_out <= 1'b1;
        end else if (!watchdog_fault_output_n_out && wdo_cnt >= wdo_limit) begin
            watchdog_fault_output_n_out <= 1'b1; // R9
            watchdog_fault_output_oe_out <= 1'b0;
        end else if (!watchdog_fault_output_n_out && tick) begin
            wdo_cnt <= wdo_cnt + 18'h00001;
        end
    end

    // ****************************************
    // Interrupt and status events
    // ****************************************
    assign events.fast = fast_det;
    assign events.error_signal_input = esm_det;
    assign events.wdog = watchdog_violation_in;
    assign events.ready = go_ready;
    wire logic irq_live = |(status & mask); // R6

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            interrupt_output_n_out <= 1'b1;
            interrupt_output_oe_out <= 1'b0;
            ready_out <= 1'b0;
            serial_active_out <= 1'b0;
        end else begin
            interrupt_output_n_out <= !irq_live; // R6
            interrupt_output_oe_out <= irq_live;
            ready_out <= ready | go_ready;
            serial_active_out <= ready | go_ready; // R3
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    wire logic [31:0] state_word = {24'h000000, !watchdog_fault_output_n_out,
        !reset_output_n_out, esm_det, fast_det, test_sel, ready};
    logic [31:0] rd_mux;

    always_comb begin
        unique case (addr_in)
            `SVTS_ADDR_CTRL: rd_mux = {24'h000000, ctrl};
            `SVTS_ADDR_FILT: rd_mux = {2'h0, filt};
            `SVTS_ADDR_STATUS: rd_mux = {26'h0000000, status};
            `SVTS_ADDR_MASK: rd_mux = {26'h0000000, mask};
            `SVTS_ADDR_STATE: rd_mux = state_word;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 32'h00000000;
        end else begin
            rd_data_out <= acc_rd ? rd_mux : 32'h00000000;
        end
    end

endmodule

//--- tb/svts_bench.sv
// Self-checking bench of the supervisor timing sequencer
// Assumes a 100 us timebase tick
`timescale 1ns/100ps
`include "svts_regs.svh"
module svts_bench;
    localparam int TK = 100;
    localparam int CPT = TK * 10;
    logic clk_in = 0, rst_n_in = 0, strap = 0, error_signal_input = 0, wdv = 0, wr = 0, rd = 0;
    logic [2:0] fast = 0;
    logic [7:0] addr = 0;
    logic [31:0] wd = 0, d, seed = 32'hCA659AB5;
    logic [9:0] fn;
    wire [31:0] rdata;
    wire rst_oe, wdo_oe, irq_oe, rdy, ser, rst_pin, wdo_pin, irq_pin;
    int bad_count = 0, n_tests = 0, i, c, n, ch, ec, rc;
    int rdly_us[8] = '{`SVTS_RDLY0_US, `SVTS_RDLY1_US, `SVTS_RDLY2_US, `SVTS_RDLY3_US,
        `SVTS_RDLY4_US, `SVTS_RDLY5_US, `SVTS_RDLY6_US, `SVTS_RDLY7_US};
    int esm_us[4] = '{`SVTS_ESM0_US, `SVTS_ESM1_US, `SVTS_ESM2_US, `SVTS_ESM3_US};

    svts_top #(.TICK_US(TK)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .self_test_on_power_up_in(strap), .fast_fault_in(fast), .error_signal_input_in(error_signal_input),
        .watchdog_violation_in(wdv), .addr_in(addr), .wr_data_in(wd), .wr_en_in(wr),
        .rd_en_in(rd), .rd_data_out(rdata), .reset_output_n_out(), .reset_output_oe_out(rst_oe),
        .watchdog_fault_output_n_out(), .watchdog_fault_output_oe_out(wdo_oe),
        .interrupt_output_n_out(), .interrupt_output_oe_out(irq_oe), .ready_out(rdy),
        .serial_active_out(ser));
    svts_soc_model soc_u (.rst_oe_in(rst_oe), .wdo_oe_in(wdo_oe), .irq_oe_in(irq_oe),
        .rst_pin_out(rst_pin), .wdo_pin_out(wdo_pin), .irq_pin_out(irq_pin));

    initial begin
        forever #50 clk_in = ~clk_in;
    end

    // ****
    // Helpers
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    function automatic int tk(input int us);
        return (us / TK < 1) ? 1 : us / TK;
    endfunction
    function automatic logic sel(input int w);
        case (w)
            0: return rst_pin;
            1: return wdo_pin;
            2: return irq_pin;
            default: return rdy;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        n_tests++;
        if (g < lo || g > hi) begin
            bad_count++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        wr <= 1;
        addr <= a;
        wd <= v;
        @(posedge clk_in);
        wr <= 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_in);
        rd <= 1;
        addr <= a;
        @(posedge clk_in);
        rd <= 0;
        #1;
        v = rdata;
        @(posedge clk_in);
    endtask
    task automatic wait_pin(input int w, input logic lvl, input int lim, output int k);
        k = 0;
        while (sel(w) !== lvl && k < lim) begin
            @(posedge clk_in);
            #1;
            k++;
        end
    endtask
    task automatic rel_check(input int code);
        int t;
        t = tk(rdly_us[code]);
        wait_pin(0, 1, (t + 2) * CPT, n);
        chk_rng("reset release", (t - 1) * CPT, (t + 1) * CPT + 8, n);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk_in);
        bad_count++;
        finish_test;
    end

    // ****
    // Scenarios
    // ****
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1;
        rd_reg(`SVTS_ADDR_MASK, d);
        chk("early read", 32'h0, d);
        wait_pin(3, 1, 30000, n);
        chk_rng("ready time", 1, 20000, n);
        chk("serial active", 1, ser);
        chk("reset held", 0, rst_pin);
        rd_reg(`SVTS_ADDR_CTRL, d);
        chk("ctrl reset", 32'h0, d);
        rd_reg(`SVTS_ADDR_FILT, d);
        chk("filter reset", 32'h3FFFFFFF, d);
        rd_reg(`SVTS_ADDR_MASK, d);
        chk("mask reset", 32'h1F, d);
        rd_reg(8'h20, d);
        chk("unmapped", 32'h0, d);
        rel_check(0);
        for (c = 0; c < 8; c++) begin
            wr_reg(`SVTS_ADDR_CTRL, {24'h0, 2'(c), 3'(c), 3'(c)});
            rd_reg(`SVTS_ADDR_CTRL, d);
            chk("ctrl codes", {24'h0, 2'(c), 3'(c), 3'(c)}, d);
        end
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            ch = seed[7:0] % 3;
            fn = (i == 0) ? 10'h0 : (i == 1) ? 10'h3FF : seed[17:8];
            rc = (i == 1) ? 1 : 0;
            wr_reg(`SVTS_ADDR_CTRL, 32'(rc));
            wr_reg(`SVTS_ADDR_FILT, {2'b0, fn, fn, fn});
            @(posedge clk_in);
            fast[ch] <= 1;
            wait_pin(0, 0, 2000, n);
            chk_rng("fast detect", fn + 2, fn + 6, n);
            wait_pin(2, 0, 4, n);
            chk_rng("fast irq", 0, 2, n);
            rd_reg(`SVTS_ADDR_STATUS, d);
            chk("fast status", 1, d[ch]);
            fast <= 0;
            rel_check(rc);
            wr_reg(`SVTS_ADDR_STATUS, 32'h3F);
            repeat (3) @(posedge clk_in);
            chk("irq cleared", 1, irq_pin);
        end
        wr_reg(`SVTS_ADDR_MASK, 32'h0);
        wr_reg(`SVTS_ADDR_FILT, 32'h0);
        fast[1] <= 1;
        wait_pin(0, 0, 30, n);
        repeat (20) @(posedge clk_in);
        chk("masked irq", 1, irq_pin);
        fast <= 0;
        rel_check(rc);
        wr_reg(`SVTS_ADDR_STATUS, 32'h3F);
        wr_reg(`SVTS_ADDR_MASK, 32'h1F);
        repeat (3) @(posedge clk_in);
        chk("unmasked idle", 1, irq_pin);
        for (c = 0; c < 4; c++) begin
            ec = esm_us[c] * 10;
            wr_reg(`SVTS_ADDR_CTRL, {24'h0, 2'(c), 6'h00});
            error_signal_input <= 1;
            repeat (ec - 20) @(posedge clk_in);
            error_signal_input <= 0;
            repeat (10) @(posedge clk_in);
            rd_reg(`SVTS_ADDR_STATUS, d);
            chk("short error", 0, d[3]);
            error_signal_input <= 1;
            wait_pin(2, 0, ec + 50, n);
            chk_rng("error irq", ec, ec + 8, n);
            @(posedge clk_in) error_signal_input <= 0;
            rel_check(0);
            wr_reg(`SVTS_ADDR_STATUS, 32'h3F);
        end
        wdv <= 1;
        @(posedge clk_in);
        wdv <= 0;
        wait_pin(1, 0, 5, n);
        chk_rng("watchdog assert", 0, 2, n);
        chk("watchdog reset", 0, rst_pin);
        rel_check(0);
        repeat (5 * CPT) @(posedge clk_in);
        wdv <= 1;
        @(posedge clk_in);
        wdv <= 0;
        wait_pin(1, 1, 15 * CPT, n);
        chk_rng("watchdog hold", tk(`SVTS_WDLY0_US) * CPT - CPT, (tk(`SVTS_WDLY0_US) + 1) * CPT + 8, n);
        finish_test;
    end
endmodule

//--- tb/svts_checker_asserts.sv
// Concurrent checks on the supervisor timing sequencer ports
// Assumes one 10 MHz clock and a strap held steady through power-up
`timescale 1ns/100ps
module svts_checker import svts_pkg::*; #(
    parameter int TICK_US = 1
) (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Async reset, active low
    input wire logic self_test_on_power_up_in, // Strap
    input wire logic [2:0] fast_fault_in, // Fast fault pins
    input wire logic error_signal_input_in, // Error pin
    input wire logic watchdog_violation_in, // Watchdog pulse
    input wire logic rd_en_in, // Read strobe
    input wire logic [31:0] rd_data_out, // Read data
    input wire logic reset_output_n_out, // Reset level
    input wire logic reset_output_oe_out, // Reset enable
    input wire logic watchdog_fault_output_n_out, // Watchdog level
    input wire logic watchdog_fault_output_oe_out, // Watchdog enable
    input wire logic interrupt_output_n_out, // Interrupt level
    input wire logic interrupt_output_oe_out, // Interrupt enable
    input wire logic ready_out, // Ready
    input wire logic serial_active_out // Register access open
);
    logic [17:0] up_cnt;
    logic [10:0] fcnt;
    logic [10:0] ecnt;

    // ****
    // Cycle counters
    // ****
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_cnt <= '0;
            fcnt <= '0;
            ecnt <= '0;
        end else begin
            up_cnt <= (!ready_out && up_cnt != 18'h3FFFF) ? up_cnt + 18'h1 : up_cnt;
            fcnt <= !(ready_out && |fast_fault_in) ? 11'h0 : fcnt + {10'h0, fcnt != 11'h7FF};
            ecnt <= !(ready_out && error_signal_input_in) ? 11'h0 :
                ecnt + {10'h0, ecnt != 11'h7FF};
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_wd_hit;
        ready_out && watchdog_violation_in;
    endsequence

    // ****
    // Assertions
    // ****
    AST_UP_TEST: assert property (self_test_on_power_up_in && !ready_out |-> up_cnt < 18'h1D4C0)
        else $error("ready late with self test");
    AST_UP_PLAIN: assert property (!self_test_on_power_up_in && !ready_out |-> up_cnt < 18'h04E20)
        else $error("ready late without self test");
    AST_READY_STAYS: assert property (ready_out |=> ready_out)
        else $error("ready dropped");
    AST_SERIAL: assert property (serial_active_out == ready_out)
        else $error("register access differs from ready");
    AST_RD_ZERO: assert property (rd_data_out != 32'h0 |-> $past(rd_en_in) && $past(ready_out))
        else $error("read data without accepted read");
    AST_WD_OUT: assert property (s_wd_hit |=> !watchdog_fault_output_n_out)
        else $error("watchdog output late");
    AST_WD_RST: assert property (s_wd_hit |-> ##[1:2] !reset_output_n_out)
        else $error("reset late after watchdog fault");
    AST_PIN_OE: assert property (reset_output_oe_out == !reset_output_n_out
        && watchdog_fault_output_oe_out == !watchdog_fault_output_n_out
        && interrupt_output_oe_out == !interrupt_output_n_out)
        else $error("pin enable disagrees with level");
    AST_HOLD: assert property (!ready_out |-> !reset_output_n_out)
        else $error("reset released before ready");
    AST_FAST: assert property (fcnt == 11'h406 |-> !reset_output_n_out)
        else $error("fast fault beyond longest filter undetected");
    AST_ESM: assert property (ecnt == 11'h3F8 |-> !reset_output_n_out)
        else $error("error input beyond longest debounce undetected");
endmodule

bind svts_top svts_checker #(.TICK_US(TICK_US)) chk_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .self_test_on_power_up_in(self_test_on_power_up_in),
    .fast_fault_in(fast_fault_in), .error_signal_input_in(error_signal_input_in),
    .watchdog_violation_in(watchdog_violation_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .reset_output_n_out(reset_output_n_out),
    .reset_output_oe_out(reset_output_oe_out),
    .watchdog_fault_output_n_out(watchdog_fault_output_n_out),
    .watchdog_fault_output_oe_out(watchdog_fault_output_oe_out),
    .interrupt_output_n_out(interrupt_output_n_out),
    .interrupt_output_oe_out(interrupt_output_oe_out), .ready_out(ready_out),
    .serial_active_out(serial_active_out));

//--- tb/svts_soc_model.sv
// System side of the three open-drain outputs
// Assumes each enable is high while the supervisor pulls its wire low
`timescale 1ns/100ps
module svts_soc_model (
    input wire logic rst_oe_in, // Reset wire pulled low
    input wire logic wdo_oe_in, // Watchdog wire pulled low
    input wire logic irq_oe_in, // Interrupt wire pulled low
    output logic rst_pin_out, // Reset wire level
    output logic wdo_pin_out, // Watchdog wire level
    output logic irq_pin_out // Interrupt wire level
);
    // Pull-ups hold each released wire high
    assign rst_pin_out = rst_oe_in ? 1'b0 : 1'b1;
    assign wdo_pin_out = wdo_oe_in ? 1'b0 : 1'b1;
    assign irq_pin_out = irq_oe_in ? 1'b0 : 1'b1;
endmodule
